// ==== rtl/sdc_defs.svh ====
// Constants for the sensor part_identification, status and control register bank
// Assumes a 25 MHz core clock and a register access port from the bus layer
//
// How it works
// - Part id read-only: revision, part code
// - Capabilities read-only: one temperature function
// - Event flag set by function event
// - Reading result register clears event flag
// - Error flag set by function error
// - Unread result overwritten sets error flag
// - Reserved status bits read zero
// - Bus error flag set on no-acknowledge
// - Bus error clears on status read
// - Status and control reset to zero
// - Broadcast writes touch only control bits 1-0
// - Reset bit starts reset, self-clears after
// - Device reset aborts and reloads all registers
// - Shutdown bit halts all functions
// - Low-power bit slows functions
// - Low-power scan rate is one quarter
// - Control bits 3, 15-5 read zero
// - Function enable bit gates measurement function
// - Function registers accessible while disabled
`ifndef SDC_DEFS_SVH
`define SDC_DEFS_SVH

// ==========================================================
// Register indices
`define SDC_ADDR_PART_ID     6'h02
`define SDC_ADDR_FIXED_CAPS  6'h03
`define SDC_ADDR_FLAGS       6'h04
`define SDC_ADDR_MODE_CTRL   6'h05
`define SDC_BCAST_DEV        3'h0

// ==========================================================
// Field positions
`define SDC_ST_EVENT_BIT     0
`define SDC_ST_ERROR_BIT     4
`define SDC_ST_NACK_BIT      7
`define SDC_CT_RESET_BIT     0
`define SDC_CT_SHUT_BIT      1
`define SDC_CT_LOW_POWER_SELECT_BIT    2
`define SDC_CT_ENABLE_BIT    4

// ==========================================================
// Reset values and fixed contents
`define SDC_FLAGS_RST        8'h00
`define SDC_CTRL_RST         16'h0000
`define SDC_CAPS_VALUE       16'h0001
`define SDC_CTRL_WMASK       16'h0017
`define SDC_CTRL_BMASK       16'h0003

// ==========================================================
// Timing
`define SDC_RST_CYCLES       4'h8
`define SDC_LOW_POWER_SELECT_DIV       2'h3

`endif

// ==== rtl/sdc_pkg.sv ====
// Types for the sensor device register bank
// Assumes sdc_defs.svh provides the numeric constants
package sdc_pkg;
   typedef enum logic [1:0] {
      SDC_RUN      = 2'b00,
      SDC_RESET    = 2'b01,
      SDC_RESTART  = 2'b11
   } sdc_state_e;
   typedef logic [15:0] sdc_word_t;
endpackage : sdc_pkg

// ==== rtl/sdc_rate_div.sv ====
// Scan-tick divider for low-power mode
// Assumes a single clock domain, synchronous active-low reset
`timescale 1ns/10ps
`include "sdc_defs.svh"
module sdc_rate_div
   import sdc_pkg::*;
(
   // Clock and reset
   input  wire logic ref_clk_i,
   input  wire logic reset_n_i,
   // Ticks
   input  wire logic clear_i,
   input  wire logic slow_i,
   input  wire logic tick_i,
   output logic      tick_o
);
   logic [1:0] cnt_r;

   // ==========================================================
   // Divide by four in low power, pass through in active mode
   always_ff @(posedge ref_clk_i)
   begin
      if (!reset_n_i || clear_i)
      begin
         cnt_r <= 2'h0;
      end
      else if (tick_i)
      begin
         cnt_r <= cnt_r + 2'h1;
      end
   end

   assign tick_o = tick_i && (!slow_i || cnt_r == `SDC_LOW_POWER_SELECT_DIV);
endmodule : sdc_rate_div

// ==== rtl/sdc_regs.sv ====
// Sensor part_identification, status and control register bank
// Assumes register accesses arrive as one-cycle strobes from the bus layer
`timescale 1ns/10ps
`include "sdc_defs.svh"
module sdc_regs
   import sdc_pkg::*;
#(
   // Arbitrary neutral identity values
   parameter logic [4:0]  DIE_REV   = 5'h01,
   parameter logic [10:0] PART_CODE = 11'h055
)
(
   // Clock and reset
   input  wire logic        ref_clk_i,
   input  wire logic        reset_n_i,
   // Register access
   input  wire logic        rd_i,
   input  wire logic        wr_i,
   input  wire logic        bcast_i,
   input  wire logic [5:0]  addr_i,
   input  wire logic [15:0] wdata_i,
   output logic      [15:0] rdata_o,
   // Bus layer and function events
   input  wire logic        nack_i,
   input  wire logic        func_event_i,
   input  wire logic        func_error_i,
   input  wire logic        result_read_i,
   input  wire logic        scan_tick_i,
   // Control to the function
   output logic             dev_reset_o,
   output logic             func_run_o,
   output logic             low_power_o,
   output logic             shutdown_o,
   output logic             scan_tick_o
);
   sdc_state_e  state_r;
   logic [3:0]  rst_cnt_r;
   logic [3:0]  rst_len_r;
   logic [15:0] ctrl_r;
   logic        function_event_flag_r;
   logic        function_error_flag_r;
   logic        bus_nack_error_flag_r;
   logic        soft_rst;
   logic        wr_ctrl;
   logic        rd_flags;
   logic        tick;
   sdc_word_t   rd_mux;
   logic [15:0] part_identification;

   assign part_identification = {DIE_REV, PART_CODE};
   assign soft_rst = (state_r != SDC_RUN);
   assign wr_ctrl  = wr_i && addr_i == `SDC_ADDR_MODE_CTRL;
   assign rd_flags = rd_i && addr_i == `SDC_ADDR_FLAGS;

   // ==========================================================
   // Device reset sequencer
   always_ff @(posedge ref_clk_i)
   begin
      if (!reset_n_i)
      begin
         state_r   <= SDC_RUN;
         rst_cnt_r <= 4'h0;
      end
      else
      begin
         case (state_r)
            SDC_RUN:
            begin
               if (wr_ctrl && wdata_i[`SDC_CT_RESET_BIT])
               begin
                  state_r   <= SDC_RESET;
                  rst_cnt_r <= `SDC_RST_CYCLES;
               end
            end
            SDC_RESET:
            begin
               if (rst_cnt_r == 4'h1)
               begin
                  state_r <= SDC_RESTART;
               end
               rst_cnt_r <= rst_cnt_r - 4'h1;
            end
            default:
            begin
               state_r <= SDC_RUN;
            end
         endcase
      end
   end

   // ==========================================================
   // Control register
   always_ff @(posedge ref_clk_i)
   begin
      if (!reset_n_i)
      begin
         ctrl_r <= `SDC_CTRL_RST;
      end
      else if (state_r == SDC_RESTART)
      begin
         ctrl_r <= `SDC_CTRL_RST;
      end
      else if (state_r == SDC_RUN && wr_ctrl)
      begin
         if (bcast_i)
         begin
            // Broadcast leaves upper bits intact
            ctrl_r <= (ctrl_r & ~`SDC_CTRL_BMASK) | (wdata_i & `SDC_CTRL_BMASK);
         end
         else
         begin
            ctrl_r <= wdata_i & `SDC_CTRL_WMASK;
         end
      end
   end

   // ==========================================================
   // Status flags; a set in the clearing cycle wins
   always_ff @(posedge ref_clk_i)
   begin
      if (!reset_n_i || soft_rst)
      begin
         function_event_flag_r <= 1'b0;
         function_error_flag_r <= 1'b0;
         bus_nack_error_flag_r <= 1'b0;
      end
      else
      begin
         if (func_event_i)
         begin
            function_event_flag_r <= 1'b1;
         end
         else if (result_read_i)
         begin
            function_event_flag_r <= 1'b0;
         end
         if (func_error_i || (func_event_i && function_event_flag_r))
         begin
            function_error_flag_r <= 1'b1;
         end
         else if (result_read_i)
         begin
            function_error_flag_r <= 1'b0;
         end
         if (nack_i)
         begin
            bus_nack_error_flag_r <= 1'b1;
         end
         else if (rd_flags)
         begin
            bus_nack_error_flag_r <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Read mux, plain decode
   always_comb
   begin
      rd_mux = 16'h0000;
      if (addr_i == `SDC_ADDR_PART_ID)
      begin
         rd_mux = part_identification;
      end
      else if (addr_i == `SDC_ADDR_FIXED_CAPS)
      begin
         rd_mux = `SDC_CAPS_VALUE;
      end
      else if (addr_i == `SDC_ADDR_FLAGS)
      begin
         rd_mux = {8'h00, bus_nack_error_flag_r, 2'b00, function_error_flag_r,
                   3'b000, function_event_flag_r};
      end
      else if (addr_i == `SDC_ADDR_MODE_CTRL)
      begin
         rd_mux = ctrl_r | {15'h0000, soft_rst};
      end
   end

   sdc_rate_div u_div (
      .ref_clk_i (ref_clk_i),
      .reset_n_i (reset_n_i),
      .clear_i   (soft_rst),
      .slow_i    (ctrl_r[`SDC_CT_LOW_POWER_SELECT_BIT]),
      .tick_i    (scan_tick_i),
      .tick_o    (tick)
   );

   // ==========================================================
   // Registered outputs
   always_ff @(posedge ref_clk_i)
   begin
      if (!reset_n_i)
      begin
         rdata_o     <= 16'h0000;
         dev_reset_o <= 1'b0;
         func_run_o  <= 1'b0;
         low_power_o <= 1'b0;
         shutdown_o  <= 1'b0;
         scan_tick_o <= 1'b0;
      end
      else
      begin
         // Function registers stay reachable elsewhere whatever enable says
         rdata_o     <= rd_i ? rd_mux : 16'h0000;
         dev_reset_o <= soft_rst;
         shutdown_o  <= ctrl_r[`SDC_CT_SHUT_BIT];
         low_power_o <= ctrl_r[`SDC_CT_LOW_POWER_SELECT_BIT] && !ctrl_r[`SDC_CT_SHUT_BIT];
         func_run_o  <= ctrl_r[`SDC_CT_ENABLE_BIT] && !ctrl_r[`SDC_CT_SHUT_BIT]
                        && !soft_rst;
         scan_tick_o <= tick && ctrl_r[`SDC_CT_ENABLE_BIT]
                        && !ctrl_r[`SDC_CT_SHUT_BIT] && !soft_rst;
      end
   end

   // ==========================================================
   // Soft reset length; a long repetition would be too costly in the check
   always_ff @(posedge ref_clk_i)
   begin
      if (!reset_n_i || !soft_rst)
      begin
         rst_len_r <= 4'h0;
      end
      else
      begin
         rst_len_r <= rst_len_r + 4'h1;
      end
   end

   // ==========================================================
   // Checks
   property p_nack_set;
      @(posedge ref_clk_i) disable iff (!reset_n_i)
      (nack_i && !soft_rst) |=> bus_nack_error_flag_r;
   endproperty
   a_nack_set: assert property (p_nack_set) else $error("nack flag missed");

   property p_nack_clr;
      @(posedge ref_clk_i) disable iff (!reset_n_i)
      (rd_flags && !nack_i) |=> !bus_nack_error_flag_r;
   endproperty
   a_nack_clr: assert property (p_nack_clr) else $error("nack not cleared");

   property p_evt;
      @(posedge ref_clk_i) disable iff (!reset_n_i)
      (func_event_i && !soft_rst) |=> function_event_flag_r;
   endproperty
   a_evt: assert property (p_evt) else $error("event flag missed");

   property p_evt_clr;
      @(posedge ref_clk_i) disable iff (!reset_n_i)
      (result_read_i && !func_event_i) |=> !function_event_flag_r;
   endproperty
   a_evt_clr: assert property (p_evt_clr) else $error("event not cleared");

   property p_ovr;
      @(posedge ref_clk_i) disable iff (!reset_n_i)
      (func_event_i && function_event_flag_r && !soft_rst) |=> function_error_flag_r;
   endproperty
   a_ovr: assert property (p_ovr) else $error("overrun missed");

   property p_rsv;
      @(posedge ref_clk_i) disable iff (!reset_n_i)
      rd_flags |=> (rdata_o[6:5] == 2'b00 && rdata_o[3:1] == 3'b000);
   endproperty
   a_rsv: assert property (p_rsv) else $error("reserved status bits set");

   property p_selfclr;
      @(posedge ref_clk_i) disable iff (!reset_n_i)
      (state_r == SDC_RUN && wr_ctrl && wdata_i[`SDC_CT_RESET_BIT])
         |=> soft_rst ##8 (soft_rst && rst_len_r == 4'h8) ##1 !soft_rst;
   endproperty
   a_selfclr: assert property (p_selfclr) else $error("reset bit length wrong");

   property p_ctrl_zero;
      @(posedge ref_clk_i) disable iff (!reset_n_i)
      (state_r == SDC_RESTART) |=> (ctrl_r == 16'h0000 && !function_error_flag_r);
   endproperty
   a_ctrl_zero: assert property (p_ctrl_zero) else $error("not reset to zero");

   property p_bcast;
      @(posedge ref_clk_i) disable iff (!reset_n_i)
      (state_r == SDC_RUN && wr_ctrl && bcast_i) |=> ctrl_r[15:2] == $past(ctrl_r[15:2]);
   endproperty
   a_bcast: assert property (p_bcast) else $error("broadcast touched upper");

   property p_shut;
      @(posedge ref_clk_i) disable iff (!reset_n_i)
      ctrl_r[`SDC_CT_SHUT_BIT] |=> (!func_run_o && !low_power_o && !scan_tick_o);
   endproperty
   a_shut: assert property (p_shut) else $error("shutdown not halting");

   property p_low_power_select;
      @(posedge ref_clk_i) disable iff (!reset_n_i)
      (ctrl_r[`SDC_CT_LOW_POWER_SELECT_BIT] && !ctrl_r[`SDC_CT_SHUT_BIT]) |=> low_power_o;
   endproperty
   a_low_power_select: assert property (p_low_power_select) else $error("low power not shown");

   property p_rst_halt;
      @(posedge ref_clk_i) disable iff (!reset_n_i)
      soft_rst |=> (!func_run_o && !scan_tick_o && dev_reset_o);
   endproperty
   a_rst_halt: assert property (p_rst_halt) else $error("reset not halting");

   property p_ctrl_rsv;
      @(posedge ref_clk_i) disable iff (!reset_n_i)
      (rd_i && addr_i == `SDC_ADDR_MODE_CTRL) |=> (rdata_o[15:5] == 11'h000 && !rdata_o[3]);
   endproperty
   a_ctrl_rsv: assert property (p_ctrl_rsv) else $error("control spare bits set");
endmodule : sdc_regs

// ==== verif/sdc_bus_master.sv ====
// Bus master model issuing register strobes to the bank
// Assumes one clock; strobes change 1 ns after the rising edge
`timescale 1ns/10ps
module sdc_bus_master
   import sdc_pkg::*;
(
   // Clock
   input  wire logic        ref_clk_i,
   // Register access
   output logic             rd_o,
   output logic             wr_o,
   output logic             bcast_o,
   output logic [5:0]       addr_o,
   output sdc_word_t        wdata_o,
   input  wire logic [15:0] rdata_i
);
   // ==========================================
   // Strobes
   // No soft reset is sent before first use
   // Function needs no setup before enabling
   initial
   begin
      rd_o = 1'b0;
      wr_o = 1'b0;
      bcast_o = 1'b0;
      addr_o = 6'h00;
      wdata_o = 16'h0000;
   end

   task automatic access(input logic rd, input logic bc, input logic [5:0] a,
                         input sdc_word_t d, output sdc_word_t q);
   begin
      @(posedge ref_clk_i);
      #1;
      rd_o = rd;
      wr_o = !rd;
      bcast_o = bc;
      addr_o = a;
      wdata_o = d;
      @(posedge ref_clk_i);
      #1;
      rd_o = 1'b0;
      wr_o = 1'b0;
      // Released lines flip so stale values cannot pass
      addr_o = ~a;
      wdata_o = ~d;
      q = rdata_i;
   end
   endtask : access
endmodule : sdc_bus_master

// ==== verif/test_sensor_part_identification_status_control.sv ====
// Self-checking bench for the id, status and control bank
// Assumes sdc_regs and sdc_bus_master are compiled first
`timescale 1ns/10ps
`include "sdc_defs.svh"
module test_sensor_part_identification_status_control
   import sdc_pkg::*;
;
   logic      ref_clk_i = 1'b0;
   logic      reset_n_i = 1'b0;
   logic [4:0] fn = 5'h00;
   logic      rd, wr, bc, dev_rst, run, lp, shut, tick_o;
   logic [5:0] addr;
   sdc_word_t wdata, rdata, q;
   int        miscompares = 0;
   int        comparisons = 0;
   int        cycles = 0;
   int        ticks = 0;
   int        rst_cycles = 0;
   int        n;
   localparam logic [5:0] CT = `SDC_ADDR_MODE_CTRL;
   localparam logic [5:0] FL = `SDC_ADDR_FLAGS;

   // ==========================================
   // Design and master
   sdc_regs #(.DIE_REV(5'h03), .PART_CODE(11'h1a5)) dut_u (
      .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .rd_i(rd), .wr_i(wr),
      .bcast_i(bc), .addr_i(addr), .wdata_i(wdata), .rdata_o(rdata),
      .nack_i(fn[4]), .func_event_i(fn[3]), .func_error_i(fn[2]),
      .result_read_i(fn[1]), .scan_tick_i(fn[0]), .dev_reset_o(dev_rst),
      .func_run_o(run), .low_power_o(lp), .shutdown_o(shut), .scan_tick_o(tick_o));
   sdc_bus_master master_u (.ref_clk_i(ref_clk_i), .rd_o(rd), .wr_o(wr), .bcast_o(bc),
      .addr_o(addr), .wdata_o(wdata), .rdata_i(rdata));

   // ==========================================
   // Clock, counters and timeout
   initial
   begin
      forever #20 ref_clk_i = ~ref_clk_i;
   end
   always @(posedge ref_clk_i)
   begin
      cycles++;
      if (tick_o === 1'b1) ticks++;
      if (dev_rst === 1'b1) rst_cycles++;
      // Whole run needs well under 1000 cycles
      if (cycles == 5000)
      begin
         miscompares++;
         end_of_test();
      end
   end

   // ==========================================
   // Tasks
   task automatic check(input sdc_word_t got, input sdc_word_t exp);
   begin
      comparisons++;
      if (got !== exp)
      begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   end
   endtask : check
   task automatic rd_chk(input logic [5:0] a, input sdc_word_t e);
   begin
      master_u.access(1'b1, 1'b0, a, 16'h0000, q);
      check(q, e);
   end
   endtask : rd_chk
   task automatic wr_reg(input logic [5:0] a, input sdc_word_t d, input logic b = 1'b0);
   begin
      master_u.access(1'b0, b, a, d, q);
   end
   endtask : wr_reg
   task automatic pulse(input logic [4:0] m);
   begin
      @(posedge ref_clk_i);
      #1 fn = m;
      @(posedge ref_clk_i);
      #1 fn = 5'h00;
   end
   endtask : pulse
   // Mode word is {shutdown, low power, run}
   task automatic modes(input sdc_word_t e);
   begin
      repeat (2) @(posedge ref_clk_i);
      #1 check({13'h0000, shut, lp, run}, e);
   end
   endtask : modes
   task automatic tick_run(input sdc_word_t e);
   begin
      ticks = 0;
      repeat (8) pulse(5'h01);
      repeat (3) @(posedge ref_clk_i);
      #1 check(16'(ticks), e);
   end
   endtask : tick_run
   task automatic end_of_test();
   begin
      if (miscompares == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   end
   endtask : end_of_test

   // ==========================================
   // Main sequence
   initial
   begin
      repeat (4) @(posedge ref_clk_i);
      #1 reset_n_i = 1'b1;
      rd_chk(`SDC_ADDR_PART_ID, 16'h19a5);
      wr_reg(`SDC_ADDR_PART_ID, 16'h0000);
      rd_chk(`SDC_ADDR_PART_ID, 16'h19a5);
      rd_chk(`SDC_ADDR_FIXED_CAPS, 16'h0001);
      rd_chk(FL, 16'h0000);
      rd_chk(CT, 16'h0000);
      rd_chk(6'h3f, 16'h0000);
      wr_reg(CT, 16'hfffe);
      rd_chk(CT, 16'h0016);
      modes(16'h0004);
      tick_run(16'h0000);
      wr_reg(CT, 16'h0014);
      modes(16'h0003);
      tick_run(16'h0002);
      wr_reg(CT, 16'h0010);
      modes(16'h0001);
      tick_run(16'h0008);
      wr_reg(CT, 16'h0000);
      tick_run(16'h0000);
      pulse(5'h08);
      rd_chk(FL, 16'h0001);
      pulse(5'h08);
      rd_chk(FL, 16'h0011);
      pulse(5'h02);
      rd_chk(FL, 16'h0000);
      pulse(5'h04);
      wr_reg(FL, 16'h0000);
      rd_chk(FL, 16'h0010);
      pulse(5'h10);
      rd_chk(FL, 16'h0090);
      rd_chk(FL, 16'h0010);
      pulse(5'h0a);
      rd_chk(FL, 16'h0001);
      // Broadcast may only reach the two low bits
      wr_reg(CT, 16'h0014);
      wr_reg(CT, 16'hfffe, 1'b1);
      rd_chk(CT, 16'h0016);
      rst_cycles = 0;
      wr_reg(CT, 16'h0001);
      master_u.access(1'b1, 1'b0, CT, 16'h0000, q);
      check(q & 16'h0001, 16'h0001);
      for (n = 0; n < 40 && dev_rst === 1'b1; n++) @(posedge ref_clk_i);
      #1 check(16'(rst_cycles), 16'h0009);
      rd_chk(CT, 16'h0000);
      rd_chk(FL, 16'h0000);
      modes(16'h0000);
      end_of_test();
   end
endmodule : test_sensor_part_identification_status_control
